// >>> dpram_pkg.sv
// Shared types and constants for the two-port embedded memory block.
// Assumes one system clock; clearing and enables arrive as synchronous controls.
`default_nettype none
package dpram_pkg;

    // -----------------------------------------------------------------
    // Geometry
    // -----------------------------------------------------------------
    localparam int ADDR_W = 13;
    localparam int DEPTH = 8192;
    localparam int LANES = 8;
    localparam int LANE_W = 9;
    localparam int SLICES = 6;
    localparam int SLICE_W = 12;
    localparam int GROUP_W = 8;
    localparam int HALF_BIT = 12;

    // -----------------------------------------------------------------
    // Reset values
    // -----------------------------------------------------------------
    localparam logic [71:0] DATA_RST = 72'h0;
    localparam logic [LANES-1:0] MASK_ALL = 8'hff;

    // Clocking arrangement of the block.
    typedef enum logic [1:0] {
        MODE_INDEP = 2'b00,
        MODE_IO = 2'b01,
        MODE_RW = 2'b10,
        MODE_SINGLE = 2'b11
    } clk_mode_t;

    // A 72-bit word carried as six 12-bit slices.
    typedef logic [SLICES-1:0][SLICE_W-1:0] word_t;

    // Address carried as two 8-bit groups.
    typedef struct packed {
        logic [GROUP_W-1:0] hi;
        logic [GROUP_W-1:0] lo;
    } addr_t;

    // Request inputs of one port.
    typedef struct packed {
        word_t din;
        addr_t addr;
        logic [LANES-1:0] mask;
        logic mask_on;
        logic wr;
    } port_req_t;

    // Enables and clears of one port, for its input and output registers.
    typedef struct packed {
        logic in_ce;
        logic in_clr;
        logic out_ce;
        logic out_clr;
    } port_ctl_t;

    // Registered input side of one port.
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        word_t din;
        logic [LANES-1:0] mask;
        logic wr;
    } in_regs_t;

    // Whole register state of the block.
    typedef struct packed {
        in_regs_t a;
        in_regs_t b;
        logic rden;
        word_t a_dout;
        word_t b_dout;
    } state_t;

endpackage

`default_nettype wire

// >>> dpram_clocking.sv
// Summary of operation
// - Independent mode: port A registers follow port A enable, port B follow B.
// - Each port has its own enable and clear acting only on its registers.
// - Independent mode: every register, input and output, is clearable by its port.
// - Input/output mode works for true and simple dual-port use.
// - Input/output mode: input enable takes data, write, address; output enable takes data out.
// - Input/output mode: input and output registers have separate enables and clears.
// - Read/write mode: write side enable registers write data, address and write.
// - Read/write mode: read side enable registers read data, read address, read enable.
// - Read/write mode: each side has its own enable and its own clear.
// - Simple dual-port: read enable register has no clear, all others do.
// - Single-port mode splits the array into two independent single-port memories.
// - An unconnected byte mask behaves as all ones.
//
// Two-port memory with four clocking arrangements, modelled on one clock.
// Assumes enables and clears come from logic on i_mclk and act at the next edge.
`timescale 1ns/1ps
`default_nettype none

module dpram_clocking (
    // Clock and reset.
    input wire logic i_mclk,
    input wire logic i_rst,
    // Configuration.
    input wire dpram_pkg::clk_mode_t i_mode,
    input wire logic i_simple,
    // Port A.
    input wire dpram_pkg::port_req_t i_a,
    input wire dpram_pkg::port_ctl_t i_a_ctl,
    output dpram_pkg::word_t o_a_dout,
    // Port B, also the read side in simple dual-port use.
    input wire dpram_pkg::port_req_t i_b,
    input wire dpram_pkg::port_ctl_t i_b_ctl,
    input wire logic i_rden,
    output dpram_pkg::word_t o_b_dout
);

    // -----------------------------------------------------------------
    // Storage and state
    // -----------------------------------------------------------------
    logic [71:0] mem [dpram_pkg::DEPTH];
    dpram_pkg::state_t s_q;
    dpram_pkg::state_t s_d;
    logic simple;
    logic a_in_en, a_in_clr, a_out_en, a_out_clr;
    logic b_in_en, b_in_clr, b_out_en, b_out_clr;
    logic a_wr_go, b_wr_go;
    logic [dpram_pkg::LANES-1:0] a_mask, b_mask;
    logic [dpram_pkg::ADDR_W-1:0] a_waddr, b_waddr;
    logic [71:0] a_din_flat, b_din_flat;

    // Places an address in its half of the array when single-port mode splits it.
    function automatic logic [dpram_pkg::ADDR_W-1:0] place(input dpram_pkg::addr_t ad,
            input logic split, input logic upper);
        logic [dpram_pkg::ADDR_W-1:0] r;
        r = {ad.hi[4:0], ad.lo};
        if (split) begin
            r[dpram_pkg::HALF_BIT] = upper;
        end
        return r;
    endfunction

    // -----------------------------------------------------------------
    // Enable and clear routing per mode
    // -----------------------------------------------------------------
    // Selects which enable and clear governs each register group.
    always_comb begin
        simple = (i_mode == dpram_pkg::MODE_RW) || ((i_mode == dpram_pkg::MODE_IO) && i_simple);
        a_in_en = i_a_ctl.in_ce;
        a_in_clr = i_a_ctl.in_clr;
        a_out_en = (i_mode == dpram_pkg::MODE_IO) ? i_a_ctl.out_ce : i_a_ctl.in_ce;
        a_out_clr = (i_mode == dpram_pkg::MODE_IO) ? i_a_ctl.out_clr : i_a_ctl.in_clr;
        b_in_en = (i_mode == dpram_pkg::MODE_RW) ? i_b_ctl.out_ce : i_b_ctl.in_ce;
        b_in_clr = (i_mode == dpram_pkg::MODE_RW) ? i_b_ctl.out_clr : i_b_ctl.in_clr;
        b_out_en = (i_mode == dpram_pkg::MODE_IO || i_mode == dpram_pkg::MODE_RW) ?
            i_b_ctl.out_ce : i_b_ctl.in_ce;
        b_out_clr = (i_mode == dpram_pkg::MODE_IO || i_mode == dpram_pkg::MODE_RW) ?
            i_b_ctl.out_clr : i_b_ctl.in_clr;
    end

    // -----------------------------------------------------------------
    // Write path
    // -----------------------------------------------------------------
    // undriven mask as ones
    assign a_mask = i_a.mask_on ? i_a.mask : dpram_pkg::MASK_ALL;
    assign b_mask = i_b.mask_on ? i_b.mask : dpram_pkg::MASK_ALL;
    assign a_waddr = place(i_a.addr, i_mode == dpram_pkg::MODE_SINGLE, 1'b0);
    assign b_waddr = place(i_b.addr, i_mode == dpram_pkg::MODE_SINGLE, 1'b1);
    assign a_wr_go = !i_rst && a_in_en && !a_in_clr && i_a.wr;
    assign b_wr_go = !i_rst && b_in_en && !b_in_clr && i_b.wr && !simple;
    // Flat views of the write data, so that 9-bit lanes are cut across the 12-bit slices.
    assign a_din_flat = i_a.din;
    assign b_din_flat = i_b.din;

    // Writes the enabled byte lanes of each port into the array.
    always_ff @(posedge i_mclk) begin
        for (int l = 0; l < dpram_pkg::LANES; l++) begin
            if (a_wr_go && a_mask[l]) begin
                mem[a_waddr][l*dpram_pkg::LANE_W +: dpram_pkg::LANE_W] <=
                    a_din_flat[l*dpram_pkg::LANE_W +: dpram_pkg::LANE_W];
            end
            if (b_wr_go && b_mask[l]) begin
                mem[b_waddr][l*dpram_pkg::LANE_W +: dpram_pkg::LANE_W] <=
                    b_din_flat[l*dpram_pkg::LANE_W +: dpram_pkg::LANE_W];
            end
        end
    end

    // -----------------------------------------------------------------
    // Register state
    // -----------------------------------------------------------------
    // Next state of input, read enable and output registers.
    always_comb begin
        s_d = s_q;
        if (a_in_clr) begin
            s_d.a = '0;
        end else if (a_in_en) begin
            s_d.a.addr = a_waddr;
            s_d.a.din = i_a.din;
            s_d.a.mask = a_mask;
            s_d.a.wr = i_a.wr;
        end
        if (b_in_clr) begin
            s_d.b = '0;
        end else if (b_in_en) begin
            s_d.b.addr = b_waddr;
            s_d.b.din = i_b.din;
            s_d.b.mask = b_mask;
            s_d.b.wr = i_b.wr && !simple;
        end
        if (b_in_en) begin
            s_d.rden = i_rden;
        end
        if (a_out_clr) begin
            s_d.a_dout = dpram_pkg::DATA_RST;
        end else if (a_out_en) begin
            s_d.a_dout = mem[s_q.a.addr];
        end
        // simple use gated by read enable
        if (b_out_clr) begin
            s_d.b_dout = dpram_pkg::DATA_RST;
        end else if (b_out_en && (!simple || s_q.rden)) begin
            s_d.b_dout = mem[s_q.b.addr];
        end
    end

    // Registers the state.
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_a_dout = s_q.a_dout;
    assign o_b_dout = s_q.b_dout;

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    property p_a_in_clear;
        a_in_clr |=> (s_q.a.addr == '0) && (s_q.a.wr == 1'b0);
    endproperty
    a_a_in_clear: assert property (p_a_in_clear) else $error("port A input clear missed");

    property p_b_out_clear;
        b_out_clr |=> (o_b_dout == dpram_pkg::DATA_RST);
    endproperty
    a_b_out_clear: assert property (p_b_out_clear) else $error("port B output clear missed");

    property p_io_out_hold;
        (i_mode == dpram_pkg::MODE_IO && !i_a_ctl.out_ce && !i_a_ctl.out_clr) |=> $stable(o_a_dout);
    endproperty
    a_io_out_hold: assert property (p_io_out_hold) else $error("output moved without its enable");

    property p_a_own_ctl;
        (!i_a_ctl.in_ce && !i_a_ctl.in_clr) |=> $stable(s_q.a);
    endproperty
    a_a_own_ctl: assert property (p_a_own_ctl) else $error("port A inputs moved without enable");

    property p_rden_no_clr;
        (simple && b_in_clr && !b_in_en) |=> $stable(s_q.rden);
    endproperty
    a_rden_no_clr: assert property (p_rden_no_clr) else $error("read enable was cleared");

    property p_rw_read_hold;
        (i_mode == dpram_pkg::MODE_RW && !i_b_ctl.out_ce && !i_b_ctl.out_clr)
            |=> $stable(s_q.b.addr) && $stable(s_q.rden);
    endproperty
    a_rw_read_hold: assert property (p_rw_read_hold) else $error("read side moved without enable");

    property p_full_word_write;
        (a_wr_go && !i_a.mask_on && !b_wr_go) |=> (mem[$past(a_waddr)] == $past(i_a.din));
    endproperty
    a_full_word_write: assert property (p_full_word_write) else $error("unmasked write lost");

    property p_single_half;
        (i_mode == dpram_pkg::MODE_SINGLE) |-> !a_waddr[dpram_pkg::HALF_BIT] && b_waddr[dpram_pkg::HALF_BIT];
    endproperty
    a_single_half: assert property (p_single_half) else $error("single-port halves overlap");

    property p_simple_gate;
        (simple && !s_q.rden && !b_out_clr) |=> $stable(o_b_dout);
    endproperty
    a_simple_gate: assert property (p_simple_gate) else $error("read data moved without read enable");

    property p_rw_no_write;
        (i_mode == dpram_pkg::MODE_RW) |-> !b_wr_go;
    endproperty
    a_rw_no_write: assert property (p_rw_no_write) else $error("read side wrote the array");

endmodule // dpram_clocking

`default_nettype wire

// >>> fabric_user.sv
// Fabric-side user logic model that drives both ports of the memory block.
// Assumes the bench calls its tasks just after a rising edge of the clock.
`timescale 1ns/1ps
`default_nettype none
module fabric_user (
    // Port drives.
    output dpram_pkg::port_req_t o_a,
    output dpram_pkg::port_req_t o_b,
    output dpram_pkg::port_ctl_t o_a_ctl,
    output dpram_pkg::port_ctl_t o_b_ctl,
    output logic o_rden
);
    // Idle at reads of address zero with both enables of each port on and the read enable off.
    initial begin
        o_a = '0;
        o_b = '0;
        o_a_ctl = 4'ha;
        o_b_ctl = 4'ha;
        o_rden = 1'b0;
    end
    task automatic req(input bit pb, input logic wr, input logic [12:0] ad,
                       input dpram_pkg::word_t d, input logic [7:0] m);
        dpram_pkg::port_req_t r;
        r = {d, {3'h0, ad}, m, (m != 8'hff), wr};
        if (pb) o_b <= r;
        else o_a <= r;
    endtask
    // Sets the enables and clears of one port.
    task automatic ctl(input bit pb, input logic [3:0] c);
        if (pb) o_b_ctl <= c;
        else o_a_ctl <= c;
    endtask
endmodule // fabric_user
`default_nettype wire

// >>> test_dpram_clocking.sv
// Self-checking bench for the two-port memory block and its clock modes.
// Assumes the fabric model drives every request input of the block.
`timescale 1ns/1ps
`default_nettype none
module test_dpram_clocking;
    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    localparam dpram_pkg::word_t D1 = 72'h123456789abcdef012;
    localparam dpram_pkg::word_t D2 = 72'hfedcba9876543210ab;
    localparam dpram_pkg::word_t D3 = 72'h0f0f0f0f0f0f0f0f0f;
    localparam logic [71:0] LO = 72'h000000000fffffffff;
    logic i_mclk = 1'b0;
    logic i_rst = 1'b1;
    dpram_pkg::clk_mode_t i_mode = dpram_pkg::MODE_INDEP;
    logic i_simple = 1'b0;
    dpram_pkg::port_req_t i_a;
    dpram_pkg::port_req_t i_b;
    dpram_pkg::port_ctl_t i_a_ctl;
    dpram_pkg::port_ctl_t i_b_ctl;
    logic i_rden;
    dpram_pkg::word_t o_a_dout;
    dpram_pkg::word_t o_b_dout;
    int n_fail = 0;
    int check_count = 0;
    // Clock of 5 ns period.
    always #2.5 i_mclk = ~i_mclk;
    fabric_user u_fab (.o_a(i_a), .o_b(i_b), .o_a_ctl(i_a_ctl), .o_b_ctl(i_b_ctl),
                       .o_rden(i_rden));
    dpram_clocking i_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_mode(i_mode),
                          .i_simple(i_simple), .i_a(i_a), .i_a_ctl(i_a_ctl),
                          .o_a_dout(o_a_dout), .i_b(i_b), .i_b_ctl(i_b_ctl),
                          .i_rden(i_rden), .o_b_dout(o_b_dout));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input dpram_pkg::word_t s, input dpram_pkg::word_t e);
        check_count++;
        if (s !== e) begin
            n_fail++;
            $display("BAD t=%0t dout %h expected %h", $time, s, e);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_mclk);
    endtask
    // One write taken at the next edge.
    task automatic wr(input bit pb, input logic [12:0] ad, input dpram_pkg::word_t d,
                      input logic [7:0] m);
        u_fab.req(pb, 1'b1, ad, d, m);
        cyc(1);
    endtask
    // Read whose data is seen two edges after the address; returns on the next edge.
    task automatic rdc(input bit pb, input logic [12:0] ad, input dpram_pkg::word_t e);
        u_fab.req(pb, 1'b0, ad, '0, 8'hff);
        cyc(2);
        #1;
        chk(pb ? o_b_dout : o_a_dout, e);
        cyc(1);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // masked and gated writes
    task automatic t_mask;
        wr(0, 13'h0010, D1, 8'hff);
        wr(0, 13'h0010, D2, 8'h0f);
        u_fab.ctl(0, 4'h2);
        wr(0, 13'h0010, D3, 8'hff);
        u_fab.ctl(0, 4'ha);
        rdc(0, 13'h0010, (D2 & LO) | (D1 & ~LO));
        rdc(1, 13'h0010, (D2 & LO) | (D1 & ~LO));
        $display("test mask done");
    endtask
    task automatic t_clear;
        u_fab.ctl(0, 4'he);
        cyc(2);
        #1;
        chk(o_a_dout, '0);
        chk(o_b_dout, (D2 & LO) | (D1 & ~LO));
        cyc(1);
        u_fab.ctl(0, 4'ha);
        $display("test clear done");
    endtask
    task automatic t_io;
        i_mode <= dpram_pkg::MODE_IO;
        wr(0, 13'h0020, D3, 8'hff);
        rdc(0, 13'h0010, (D2 & LO) | (D1 & ~LO));
        u_fab.ctl(0, 4'h8);
        rdc(0, 13'h0020, (D2 & LO) | (D1 & ~LO));
        u_fab.ctl(0, 4'ha);
        cyc(1);
        #1;
        chk(o_a_dout, D3);
        cyc(1);
        u_fab.ctl(0, 4'h9);
        cyc(1);
        #1;
        chk(o_a_dout, '0);
        cyc(1);
        u_fab.ctl(0, 4'ha);
        $display("test io done");
    endtask
    // read side gated by read enable
    task automatic t_rw;
        i_mode <= dpram_pkg::MODE_RW;
        u_fab.o_rden <= 1'b1;
        wr(0, 13'h0030, D1, 8'hff);
        wr(1, 13'h0030, D2, 8'hff);
        rdc(1, 13'h0030, D1);
        u_fab.o_rden <= 1'b0;
        rdc(1, 13'h0020, D1);
        $display("test rw done");
    endtask
    // read-side clear, kept read enable, simple input/output use
    task automatic t_side;
        wr(0, 13'h0000, D2, 8'hff);
        u_fab.o_rden <= 1'b1;
        rdc(1, 13'h0020, D3);
        u_fab.ctl(1, 4'h1);
        cyc(1);
        #1;
        chk(o_b_dout, '0);
        cyc(1);
        u_fab.ctl(1, 4'h0);
        u_fab.o_rden <= 1'b0;
        cyc(1);
        #1;
        chk(o_b_dout, '0);
        cyc(1);
        u_fab.ctl(1, 4'ha);
        cyc(1);
        #1;
        chk(o_b_dout, D2);
        cyc(1);
        i_mode <= dpram_pkg::MODE_IO;
        i_simple <= 1'b1;
        wr(1, 13'h0020, D1, 8'hff);
        rdc(0, 13'h0020, D3);
        i_simple <= 1'b0;
        $display("test side done");
    endtask
    task automatic t_single;
        i_mode <= dpram_pkg::MODE_SINGLE;
        wr(0, 13'h0040, D1, 8'hff);
        wr(1, 13'h0040, D2, 8'hff);
        rdc(0, 13'h0040, D1);
        rdc(1, 13'h0040, D2);
        $display("test single done");
    endtask
    // Watchdog far beyond the expected run of about 74 cycles.
    initial begin
        cyc(2000);
        n_fail++;
        test_done();
    end
    // Main sequence.
    initial begin
        cyc(20);
        i_rst <= 1'b0;
        #1;
        chk(o_a_dout, '0);
        cyc(1);
        t_mask();
        t_clear();
        t_io();
        t_rw();
        t_side();
        t_single();
        test_done();
    end
endmodule // test_dpram_clocking
`default_nettype wire
